//--- lane_mgr_chk_properties.sv
`timescale 1ns/100ps
module lane_mgr_chk (
  input wire SYS_CLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire PSLVERR,
  input wire MODE_8BIT,
  input wire QUAD_RESET_IN,
  input wire [3:0] CDR_LOCKED,
  input wire PLL_LOCKED,
  input wire PHY_STATUS,
  input wire [3:0] CDR_LOSS_FLAG,
  input wire PLL_LOSS_FLAG,
  input wire HALF_RATE_CLOCK,
  input wire [3:0] CHANNEL_RX_RESET,
  input wire [3:0] CHANNEL_TX_ELEC_IDLE,
  input wire QUAD_RESET
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // lock flags and quad reset follow their pins within the pin latency
  cdr_loss_a: assert property ((CDR_LOCKED == 4'h0) [*4] |-> CDR_LOSS_FLAG == 4'hF)
    else $error("cdr flag low while unlocked");
  pll_loss_a: assert property (!PLL_LOCKED [*4] |-> PLL_LOSS_FLAG)
    else $error("pll flag low while unlocked");
  quad_rst_a: assert property (QUAD_RESET_IN [*4] |-> QUAD_RESET)
    else $error("quad reset not applied");
  half_off_a: assert property (!MODE_8BIT [*4] |-> !HALF_RATE_CLOCK)
    else $error("half rate clock outside 8-bit mode");
  phy_pulse_a: assert property (PHY_STATUS |=> !PHY_STATUS)
    else $error("phy status longer than one cycle");
  // a held channel keeps its transmitter idle
  idle_held_a: assert property ((CHANNEL_RX_RESET & ~CHANNEL_TX_ELEC_IDLE) == 4'h0)
    else $error("held channel not idle");
  held_keep_a: assert property (!QUAD_RESET && CHANNEL_RX_RESET != 4'h0 &&
    CHANNEL_RX_RESET != 4'hF |=> $stable(CHANNEL_RX_RESET) || QUAD_RESET)
    else $error("channel hold changed without quad reset");
  // bus answers with exactly one wait state
  ready_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  cover property (PHY_STATUS);
  cover property (CHANNEL_RX_RESET == 4'hE);
  cover property (PSLVERR);
endmodule
bind pipe_lane_manager lane_mgr_chk lane_mgr_chk_i (.*);

//--- lane_mgr_regs.vh
// Functional notes
// - each channel raises its recovery loss flag while unlocked or still acquiring lock.
// - config client port has 6-bit address, 8-bit write data, 8-bit read data.
// - whole quad is held in reset while quad reset input is high.
// - transmit PLL loss flag is high while the PLL is not locked.
// - in 8-bit mode a half-rate clock toggled on each synchronised PCLK rising edge is driven out.
// - lane order high maps PIPE lanes 0..3 straight onto channels 0..3.
// - lane order low maps PIPE lanes 3,2,1,0 onto channels 0,1,2,3.
// - after link-up, channels of unconfigured lanes get receive reset held high; the code holds no channel when the captured vector is all zero.
// - a held channel shows inactive outputs and its transmitter stays electrically idle.
// - downgrade to two or one lane; vector 1000b keeps channel 0 active only when lane order is low, channel 3 when high.
// - in P1 with detection requested, PhyStatus reports a completed receiver detection.
// - power state 00 is P0, 10 is P1; other codes never requested.
`ifndef LANE_MGR_REGS_VH
`define LANE_MGR_REGS_VH

// apb register byte addresses
`define CTRL_ADDR 8'h00
`define STATUS_ADDR 8'h04
`define CAPTURE_ADDR 8'h08
`define CTRL_SOFT_RST_BIT 0
`define CTRL_RESET 1'b0

// status register field positions
`define ST_CAPTURED_BIT 0
`define ST_ORDER_BIT 1
`define ST_CHRST_LSB 2
`define ST_CDR_LSB 6
`define ST_PLL_BIT 10
`define ST_QRST_BIT 11

// power state and detection status codes
`define PWR_P0 2'h0
`define PWR_P1 2'h2
`define RXST_NONE 3'h0
`define RXST_DETECTED 3'h3

// timing
`define CLK_NS 50
`define DET_TIME_NS 1000
`define DET_CYC ((`DET_TIME_NS + `CLK_NS - 1) / `CLK_NS)

// width of the pin synchroniser vector
`define SYNC_W 40

`endif

//--- mac_model.sv
`timescale 1ns/100ps
module mac_model (
  output logic PCLK,
  output logic LINK_UP_PULSE,
  output logic [3:0] CFG_LANES,
  input wire logic go,
  input wire logic [3:0] lanes
);
  logic seen = 0;
  // clock compensation debug control never used, held off
  localparam bit CTC_DEBUG = 1'b0;
  // free running link clock, phase unrelated to the system clock
  initial begin
    PCLK = 0;
    LINK_UP_PULSE = 0;
    CFG_LANES = 4'h0;
    #7;
    forever #200 PCLK = ~PCLK;
  end
  // one pclk pulse per request, lane vector alongside
  always @(posedge PCLK) begin
    LINK_UP_PULSE <= go && !seen;
    CFG_LANES <= go ? lanes : 4'h0;
    seen <= go;
  end
endmodule

//--- pipe_lane_manager.v
`timescale 1ns/100ps
`include "lane_mgr_regs.vh"
module pipe_lane_manager (
  input wire SYS_CLK,
  input wire RST,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // link clock and mac support pins
  input wire PCLK,
  input wire MODE_8BIT,
  input wire LINK_UP_PULSE,
  input wire [3:0] CFG_LANES,
  input wire LANE_ORDER,
  input wire QUAD_RESET_IN,
  // serdes lock status
  input wire [3:0] CDR_LOCKED,
  input wire PLL_LOCKED,
  // pipe command and status
  input wire [1:0] POWER_STATE,
  input wire DETECT_REQ,
  input wire FAR_END_PRESENT,
  input wire [3:0] LANE_TX_ELEC_IDLE,
  output reg PHY_STATUS,
  output reg [2:0] RX_STATUS,
  output reg [3:0] LANE_LOCKED,
  // configuration client port
  input wire [5:0] SCI_ADDR,
  input wire [7:0] SCI_WDATA,
  input wire SCI_SEL_AUX,
  input wire SCI_EN_AUX,
  input wire SCI_RD,
  input wire SCI_WR_N,
  output wire [7:0] SCI_RDATA,
  // serdes facing outputs
  output reg [3:0] CDR_LOSS_FLAG,
  output reg PLL_LOSS_FLAG,
  output reg HALF_RATE_CLOCK,
  output reg [3:0] CHANNEL_RX_RESET,
  output reg [3:0] CHANNEL_TX_ELEC_IDLE,
  output reg QUAD_RESET
);

  localparam ST_IDLE = 2'h0;
  localparam ST_DETECT = 2'h1;
  localparam ST_REPORT = 2'h2;
  localparam integer DET_LAST = `DET_CYC - 1;
  // sync reset image: quad reset pin held, write strobe idle high
  localparam [`SYNC_W-1:0] SYNC_IDLE = 40'h0080000001;

  reg [`SYNC_W-1:0] sync1;
  reg [`SYNC_W-1:0] sync2;
  wire pclk_s;
  wire mode8_s;
  wire link_up_s;
  wire [3:0] cfg_s;
  wire order_s;
  wire qrst_s;
  wire [3:0] cdr_lock_s;
  wire pll_lock_s;
  wire [1:0] pwr_s;
  wire detect_s;
  wire present_s;
  wire [3:0] txei_s;
  wire [5:0] sci_addr_s;
  wire [7:0] sci_wdata_s;
  wire sel_aux_s;
  wire en_aux_s;
  wire sci_rd_s;
  wire sci_wr_n_s;

  reg pclk_d;
  wire pclk_rise;
  reg soft_rst;
  wire quad_rst_now;
  reg captured;
  reg [3:0] cfg_cap;
  wire [3:0] chan_cfg;
  wire [3:0] next_chan_rst;
  wire [3:0] chan_lock;
  reg [1:0] det_state;
  reg [4:0] det_cnt;
  reg [1:0] pwr_d;
  reg report_pulse;
  wire pwr_ok;
  wire pwr_change;
  reg sci_wr_n_d;
  wire sci_we;
  wire sci_aux;
  wire apb_access;
  wire apb_done;
  reg [31:0] rd_mux;
  reg addr_hit;

  // two-flop synchroniser for every pin from outside the clock domain
  always @(posedge SYS_CLK) begin
    if (RST) begin
      sync1 <= SYNC_IDLE; // no false strobe edge or quad reset drop
      sync2 <= SYNC_IDLE;
    end else begin
      sync1 <= {PCLK, MODE_8BIT, LINK_UP_PULSE, CFG_LANES, LANE_ORDER,
                QUAD_RESET_IN, CDR_LOCKED, PLL_LOCKED, POWER_STATE,
                DETECT_REQ, FAR_END_PRESENT, LANE_TX_ELEC_IDLE, SCI_ADDR,
                SCI_WDATA, SCI_SEL_AUX, SCI_EN_AUX, SCI_RD, SCI_WR_N};
      sync2 <= sync1;
    end
  end

  // unpack the synchronised vector
  assign {pclk_s, mode8_s, link_up_s, cfg_s, order_s, qrst_s, cdr_lock_s,
          pll_lock_s, pwr_s, detect_s, present_s, txei_s, sci_addr_s,
          sci_wdata_s, sel_aux_s, en_aux_s, sci_rd_s, sci_wr_n_s} = sync2;

  // link clock edge finder
  always @(posedge SYS_CLK) begin
    if (RST) begin
      pclk_d <= 1'b0;
    end else begin
      pclk_d <= pclk_s;
    end
  end

  assign pclk_rise = pclk_s & ~pclk_d;

  // quad reset from the pin or from software
  assign quad_rst_now = qrst_s | soft_rst;

  always @(posedge SYS_CLK) begin
    if (RST) begin
      QUAD_RESET <= 1'b1;
    end else begin
      QUAD_RESET <= quad_rst_now;
    end
  end

  // half-rate clock toggles on each link clock rising edge in 8-bit mode
  always @(posedge SYS_CLK) begin
    if (RST) begin
      HALF_RATE_CLOCK <= 1'b0;
    end else if (quad_rst_now | ~mode8_s) begin
      HALF_RATE_CLOCK <= 1'b0;
    end else if (pclk_rise) begin
      HALF_RATE_CLOCK <= ~HALF_RATE_CLOCK;
    end
  end

  // configured-lane vector caught on the first link-up seen at a pclk edge
  always @(posedge SYS_CLK) begin
    if (RST) begin
      captured <= 1'b0;
      cfg_cap <= 4'h0;
    end else if (quad_rst_now) begin
      captured <= 1'b0;
      cfg_cap <= 4'h0;
    end else if (pclk_rise & link_up_s & ~captured) begin
      captured <= 1'b1;
      cfg_cap <= cfg_s;
    end
  end

  // per-channel lane mapping, resets and idle forcing
  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : g_chan
      // channel c carries lane c when order is high, lane 3-c when low
      assign chan_cfg[c] = order_s ? cfg_cap[c] : cfg_cap[3-c];
      // all-zero vector means downgrade is unused, nothing held
      assign next_chan_rst[c] = quad_rst_now |
                                (captured & (cfg_cap != 4'h0) & ~chan_cfg[c]);
      assign chan_lock[c] = cdr_lock_s[c] & ~CHANNEL_RX_RESET[c];

      always @(posedge SYS_CLK) begin
        if (RST) begin
          CHANNEL_RX_RESET[c] <= 1'b1;
          CHANNEL_TX_ELEC_IDLE[c] <= 1'b1;
          CDR_LOSS_FLAG[c] <= 1'b1;
          LANE_LOCKED[c] <= 1'b0;
        end else begin
          CHANNEL_RX_RESET[c] <= next_chan_rst[c];
          // held channel stays electrically idle
          CHANNEL_TX_ELEC_IDLE[c] <= next_chan_rst[c] |
                                     (order_s ? txei_s[c] : txei_s[3-c]);
          CDR_LOSS_FLAG[c] <= ~cdr_lock_s[c] | quad_rst_now;
          // pipe lane c shows its channel's lock, inactive when held
          LANE_LOCKED[c] <= order_s ? chan_lock[c] : chan_lock[3-c];
        end
      end
    end
  endgenerate

  // transmit pll loss flag
  always @(posedge SYS_CLK) begin
    if (RST) begin
      PLL_LOSS_FLAG <= 1'b1;
    end else begin
      PLL_LOSS_FLAG <= ~pll_lock_s | quad_rst_now;
    end
  end

  // supported power states only
  assign pwr_ok = (pwr_s == `PWR_P0) | (pwr_s == `PWR_P1);
  assign pwr_change = (pwr_s != pwr_d) & pwr_ok &
                      ((pwr_d == `PWR_P0) | (pwr_d == `PWR_P1));

  // receiver detection sequence
  always @(posedge SYS_CLK) begin
    if (RST) begin
      det_state <= ST_IDLE;
      det_cnt <= 5'h00;
      report_pulse <= 1'b0;
      RX_STATUS <= `RXST_NONE;
    end else if (quad_rst_now) begin
      det_state <= ST_IDLE;
      det_cnt <= 5'h00;
      report_pulse <= 1'b0;
      RX_STATUS <= `RXST_NONE;
    end else begin
      report_pulse <= 1'b0;
      case (det_state)
        ST_IDLE: begin
          det_cnt <= 5'h00;
          if (detect_s & (pwr_s == `PWR_P1)) begin
            det_state <= ST_DETECT;
          end
        end
        ST_DETECT: begin
          if (~detect_s | (pwr_s != `PWR_P1)) begin
            det_state <= ST_IDLE;
          end else if (det_cnt == DET_LAST[4:0]) begin
            report_pulse <= 1'b1;
            RX_STATUS <= present_s ? `RXST_DETECTED : `RXST_NONE;
            det_state <= ST_REPORT;
          end else begin
            det_cnt <= det_cnt + 5'h01;
          end
        end
        ST_REPORT: begin
          // wait for the mac to drop its request
          if (~detect_s) begin
            det_state <= ST_IDLE;
          end
        end
        default: begin
          det_state <= ST_IDLE;
        end
      endcase
    end
  end

  // phystatus pulses on detection result and on power state changes
  always @(posedge SYS_CLK) begin
    if (RST) begin
      pwr_d <= `PWR_P0;
      PHY_STATUS <= 1'b0;
    end else begin
      pwr_d <= pwr_s;
      PHY_STATUS <= ~quad_rst_now & (report_pulse | pwr_change);
    end
  end

  // configuration client port: write on falling write strobe
  always @(posedge SYS_CLK) begin
    if (RST) begin
      sci_wr_n_d <= 1'b1;
    end else begin
      sci_wr_n_d <= sci_wr_n_s;
    end
  end

  assign sci_we = sci_wr_n_d & ~sci_wr_n_s;
  assign sci_aux = sel_aux_s & en_aux_s;

  sci_cfg_mem u_cfg_mem (
    .clk(SYS_CLK),
    .we(sci_we),
    .waddr({sci_aux, sci_addr_s}),
    .wdata(sci_wdata_s),
    .re(sci_rd_s),
    .raddr({sci_aux, sci_addr_s}),
    .rst(RST),
    .rdata(SCI_RDATA)
  );

  // apb: one wait state, write and read data at pready edge
  assign apb_access = PSEL & PENABLE & ~PREADY;
  assign apb_done = PSEL & PENABLE & PREADY;

  // read mux and address decode
  always @* begin
    rd_mux = 32'h00000000;
    addr_hit = 1'b1;
    case (PADDR)
      `CTRL_ADDR: begin
        rd_mux[`CTRL_SOFT_RST_BIT] = soft_rst;
      end
      `STATUS_ADDR: begin
        rd_mux[`ST_CAPTURED_BIT] = captured;
        rd_mux[`ST_ORDER_BIT] = order_s;
        rd_mux[`ST_CHRST_LSB+3:`ST_CHRST_LSB] = CHANNEL_RX_RESET;
        rd_mux[`ST_CDR_LSB+3:`ST_CDR_LSB] = CDR_LOSS_FLAG;
        rd_mux[`ST_PLL_BIT] = PLL_LOSS_FLAG;
        rd_mux[`ST_QRST_BIT] = QUAD_RESET;
      end
      `CAPTURE_ADDR: begin
        rd_mux[3:0] = cfg_cap;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // apb handshake and read data
  always @(posedge SYS_CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else if (apb_access) begin
      PREADY <= 1'b1;
      PSLVERR <= ~addr_hit;
      PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // control register write
  always @(posedge SYS_CLK) begin
    if (RST) begin
      soft_rst <= `CTRL_RESET;
    end else if (apb_done & PWRITE & (PADDR == `CTRL_ADDR)) begin
      soft_rst <= PWDATA[`CTRL_SOFT_RST_BIT];
    end
  end

endmodule

//--- sci_cfg_mem.v
`timescale 1ns/100ps
// configuration register store, 128 x 8, registered read
module sci_cfg_mem (
  input wire clk,
  input wire we,
  input wire [6:0] waddr,
  input wire [7:0] wdata,
  input wire re,
  input wire [6:0] raddr,
  input wire rst,
  output reg [7:0] rdata
);

  reg [7:0] mem [0:127];

  // write port
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read port, data held between reads
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule

//--- testbench.sv
`timescale 1ns/100ps
module testbench;
  logic SYS_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, e;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  logic PCLK, MODE_8BIT = 0, LINK_UP_PULSE, LANE_ORDER = 0, QUAD_RESET_IN = 1, PLL_LOCKED = 0;
  logic [3:0] CFG_LANES, CDR_LOCKED = 4'h0, LANE_TX_ELEC_IDLE = 4'h0, LANE_LOCKED, lanes = 4'h0;
  logic [3:0] CDR_LOSS_FLAG, CHANNEL_RX_RESET, CHANNEL_TX_ELEC_IDLE;
  logic [1:0] POWER_STATE = 2'h0;
  logic DETECT_REQ = 0, FAR_END_PRESENT = 0, PHY_STATUS, PLL_LOSS_FLAG, HALF_RATE_CLOCK;
  logic [2:0] RX_STATUS;
  logic [5:0] SCI_ADDR = 6'h00;
  logic [7:0] SCI_WDATA = 8'h00, SCI_RDATA;
  logic SCI_SEL_AUX = 0, SCI_EN_AUX = 0, SCI_RD = 0, SCI_WR_N = 1, QUAD_RESET, go = 0;
  int num_errors = 0, tests_run = 0, cycles = 0, n;
  pipe_lane_manager pipe_lane_manager_i (.*);
  mac_model mac_model_i (.*);
  // 20 MHz system clock
  always #25 SYS_CLK = ~SYS_CLK;
  task automatic cyc(input int k);
    repeat (k) @(posedge SYS_CLK);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // one bus transfer; result left in q and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    cyc(1);
    PENABLE <= 1;
    do begin
      cyc(1);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    cyc(1);
  endtask
  // capture a lane vector, then show a later one is ignored
  task automatic link(input logic o, input logic [3:0] v, input logic [3:0] h);
    QUAD_RESET_IN <= 1;
    cyc(5);
    QUAD_RESET_IN <= 0;
    LANE_ORDER <= o;
    lanes <= v;
    cyc(5);
    go <= 1;
    cyc(30);
    go <= 0;
    cyc(10);
    check(CHANNEL_RX_RESET, h);
    check(CHANNEL_TX_ELEC_IDLE, h);
    check(LANE_LOCKED, (v == 4'h0) ? 4'hF : v);
    lanes <= 4'hF;
    go <= 1;
    cyc(30);
    go <= 0;
    check(CHANNEL_RX_RESET, h);
  endtask
  // config port byte write or read-back
  task automatic sci(input logic [1:0] x, input logic [5:0] a, input logic [7:0] d, input logic w);
    {SCI_SEL_AUX, SCI_EN_AUX} <= x;
    SCI_ADDR <= a;
    SCI_WDATA <= d;
    cyc(4);
    if (w) begin
      SCI_WR_N <= 0;
      cyc(4);
      SCI_WR_N <= 1;
    end else begin
      SCI_RD <= 1;
      cyc(5);
      check(SCI_RDATA, d);
      SCI_RD <= 0;
    end
    cyc(4);
  endtask
  task final_report;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    cyc(2);
    RST <= 0;
    cyc(5);
    check(QUAD_RESET, 1);
    check(PLL_LOSS_FLAG, 1);
    check(CDR_LOSS_FLAG, 4'hF);
    apb(0, 8'h00, 0);
    check(q, 0);
    apb(0, 8'h0C, 0);
    check(e, 1);
    check(q, 0);
    apb(1, 8'h04, 32'hFFFF);
    QUAD_RESET_IN <= 0;
    PLL_LOCKED <= 1;
    CDR_LOCKED <= 4'h5;
    cyc(5);
    check(CDR_LOSS_FLAG, 4'hA);
    apb(0, 8'h04, 0);
    check(q, 32'h280);
    CDR_LOCKED <= 4'hF;
    link(0, 4'h8, 4'hE);
    link(1, 4'h8, 4'h7);
    link(0, 4'hC, 4'hC);
    link(1, 4'h3, 4'hC);
    link(0, 4'h0, 4'h0);
    apb(1, 8'h00, 1);
    cyc(2);
    check(QUAD_RESET, 1);
    apb(0, 8'h00, 0);
    check(q, 1);
    apb(1, 8'h00, 0);
    for (int f = 1; f >= 0; f--) begin
      POWER_STATE <= 2'h2;
      cyc(10);
      DETECT_REQ <= 1;
      FAR_END_PRESENT <= f[0];
      n = 0;
      do begin
        cyc(1);
        n++;
      end while (PHY_STATUS !== 1'b1 && n < 60);
      check(PHY_STATUS, 1);
      check(n, 25);
      check(RX_STATUS, f[0] ? 3'h3 : 3'h0);
      DETECT_REQ <= 0;
      POWER_STATE <= 2'h0;
      cyc(10);
    end
    sci(2'h0, 6'h05, 8'hA5, 1);
    sci(2'h3, 6'h05, 8'h3C, 1);
    sci(2'h3, 6'h05, 8'h3C, 0);
    sci(2'h2, 6'h05, 8'hA5, 0);
    sci(2'h1, 6'h05, 8'hA5, 0);
    MODE_8BIT <= 1;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (HALF_RATE_CLOCK !== 1'b1 && n < 60);
    check(HALF_RATE_CLOCK, 1);
    // high for one link clock period of 8 system cycles
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (HALF_RATE_CLOCK !== 1'b0 && n < 60);
    check(n, 8);
    MODE_8BIT <= 0;
    cyc(6);
    check(HALF_RATE_CLOCK, 0);
    final_report();
  end
endmodule
